//--- hw/bbt_exec.sv
// Purpose: Executes bit, skip, branch, table, watchdog, swap, halt
//   and add-with-carry instructions of an 8-bit core
// Assumes: One clock, AHB-Lite slave, PC_W above 8, STK_D power of 2
// Notes: One instruction per write of the instruction register
//
// What this block does
// - Bit clear/set forces one bit, flags kept
// - Skip-zero-move copies byte, skips on zero
// - Bit test skips on one or zero
// - Increment, write back, skip on zero
// - Decrement, write back, skip on zero
// - Skip taken two cycles, else one
// - Writing program counter low takes two cycles
// - Return loads immediate into accumulator, two cycles
// - Current-page table read fills high and memory
// - Last-page table read, same, two cycles
// - Pre-clear pair back to back clears flags
// - Lone pre-clear leaves flags unchanged
// - Smart-card register access adds one cycle
// - Nibble swap into accumulator, one cycle
// - Halt powers down within one cycle, flags
// - Add with carry into accumulator
// - Bit select covers positions zero to seven
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bbt_consts.svh"
module bbt_exec #(
  parameter int PC_W = 12,
  parameter int PM_AW = 6,
  parameter int PG_AW = 4,
  parameter int STK_D = 4,
  parameter logic [3:0] SCI_BASE = 4'hE
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wdt_timeout,
  output logic irq,
  output logic powered_down
);
  import bbt_pkg::*;

  localparam int DM_N = `BBT_DMEM_N;
  localparam int SP_W = (STK_D > 1) ? $clog2(STK_D) : 1;
  localparam int PM_N = 1 << PM_AW;
  localparam int PGN_W = PM_AW - PG_AW;

  // Bus side state
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  // Core state
  logic [7:0] dmem_ff [DM_N];
  logic [15:0] pmem_ff [PM_N];
  logic [PC_W-1:0] stack_ff [STK_D];
  logic [SP_W-1:0] sp_ff;
  logic [PC_W-1:0] pc_ff;
  logic [7:0] accumulator_ff;
  logic carry_ff;
  logic [7:0] table_high_byte_reg_ff;
  logic [7:0] table_ptr_ff;
  logic [2:0] cnt_ff;
  logic skipped_ff;
  bbt_wdt_t last_wdt_ff;
  logic timeout_flag_ff;
  logic powerdown_flag_ff;
  logic halted_ff;
  logic to_s1_ff;
  logic to_s2_ff;
  logic [`BBT_IRQ_W-1:0] irq_stat_ff;
  logic [`BBT_IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;

  // Address phase decode; only word transfers are taken
  wire ahb_go = hsel && hready && htrans[1] && (hsize == `BBT_HSIZE_WORD);
  wire [7:0] ra = haddr[7:0];
  wire ra_dmem = ra[`BBT_F_DMEM_TAG] == `BBT_DMEM_TAG;
  wire [3:0] ra_idx = ra[`BBT_F_DMEM_IDX];

  // Data phase write strobes
  wire wr_instr = dp_wr_ff && (dp_addr_ff == `BBT_OFF_INSTR);
  wire wr_ctrl = dp_wr_ff && (dp_addr_ff == `BBT_OFF_CTRL);
  wire wr_acc = dp_wr_ff && (dp_addr_ff == `BBT_OFF_ACC);
  wire wr_istat = dp_wr_ff && (dp_addr_ff == `BBT_OFF_IRQ_STAT);
  wire wr_imask = dp_wr_ff && (dp_addr_ff == `BBT_OFF_IRQ_MASK);
  wire wr_pmem = dp_wr_ff && (dp_addr_ff == `BBT_OFF_PMEM);
  wire wr_tptr = dp_wr_ff && (dp_addr_ff == `BBT_OFF_TPTR);
  wire wr_dmem = dp_wr_ff && (dp_addr_ff[`BBT_F_DMEM_TAG] == `BBT_DMEM_TAG);

  // Issue only when idle and awake; anything else is an overrun
  wire busy = |cnt_ff;
  wire issue = wr_instr && !busy && !halted_ff;
  wire overrun = wr_instr && !issue;

  // Instruction fields, taken from the write data
  wire bbt_op_t op = bbt_op_t'(hwdata[`BBT_F_OP]);
  wire [3:0] m = hwdata[`BBT_F_M];
  wire [2:0] bsel = hwdata[`BBT_F_BIT];
  wire [7:0] imm = hwdata[`BBT_F_IMM];
  wire [PC_W-1:0] jaddr = PC_W'(hwdata[`BBT_F_ADDR]);

  // Operand; address zero is the program counter low byte
  wire [7:0] m_rd = (m == `BBT_PCL_ADDR) ? pc_ff[7:0] : dmem_ff[m];
  wire [7:0] bit_mask = 8'h01 << bsel;
  wire bit_val = |(m_rd & bit_mask);
  wire [7:0] m_inc = m_rd + 8'h01;
  wire [7:0] m_dec = m_rd - 8'h01;
  wire [7:0] m_swp = {m_rd[3:0], m_rd[7:4]};
  wire [8:0] sum9 = {1'b0, accumulator_ff} + {1'b0, m_rd} + {8'h00, carry_ff};

  // Table word: current page from the program counter, or the last page
  wire last_pg = op == op_table_read_last_page;
  wire [PGN_W-1:0] cur_pg = pc_ff[PM_AW-1:PG_AW];
  wire [PGN_W-1:0] tbl_pg = last_pg ? {PGN_W{1'b1}} : cur_pg;
  wire [PM_AW-1:0] tbl_addr = {tbl_pg, table_ptr_ff[PG_AW-1:0]};
  wire [15:0] pm_word = pmem_ff[tbl_addr];

  // Per-opcode effects
  logic ex_mem_we;
  logic [7:0] ex_mem_wd;
  logic ex_acc_we;
  logic [7:0] ex_acc_wd;
  logic ex_carry_we;
  logic ex_skip;
  logic ex_mem_use;
  logic ex_two;
  logic ex_tbl;
  logic ex_jump;
  logic ex_push;
  logic ex_pop;

  // Branch and bit operations never touch carry; only add does
  always_comb begin
    ex_mem_we = 1'b0;
    ex_mem_wd = m_rd;
    ex_acc_we = 1'b0;
    ex_acc_wd = m_rd;
    ex_carry_we = 1'b0;
    ex_skip = 1'b0;
    ex_mem_use = 1'b1;
    ex_two = 1'b0;
    ex_tbl = 1'b0;
    ex_jump = 1'b0;
    ex_push = 1'b0;
    ex_pop = 1'b0;
    case (op)
      op_clr_bit: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = m_rd & ~bit_mask;
      end
      op_set_bit: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = m_rd | bit_mask;
      end
      op_skip_if_zero: ex_skip = m_rd == 8'h00;
      op_skip_zero_move_acc: begin
        ex_acc_we = 1'b1;
        ex_skip = m_rd == 8'h00;
      end
      op_skip_bit_zero: ex_skip = !bit_val;
      op_skip_bit_nonzero: ex_skip = bit_val;
      op_inc_skip_zero: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = m_inc;
        ex_skip = m_inc == 8'h00;
      end
      op_inc_skip_zero_to_acc: begin
        ex_acc_we = 1'b1;
        ex_acc_wd = m_inc;
        ex_skip = m_inc == 8'h00;
      end
      op_dec_skip_zero: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = m_dec;
        ex_skip = m_dec == 8'h00;
      end
      op_dec_skip_zero_to_acc: begin
        ex_acc_we = 1'b1;
        ex_acc_wd = m_dec;
        ex_skip = m_dec == 8'h00;
      end
      op_jump: begin
        ex_mem_use = 1'b0;
        ex_two = 1'b1;
        ex_jump = 1'b1;
      end
      op_call: begin
        ex_mem_use = 1'b0;
        ex_two = 1'b1;
        ex_jump = 1'b1;
        ex_push = 1'b1;
      end
      op_return, op_interrupt_return: begin
        ex_mem_use = 1'b0;
        ex_two = 1'b1;
        ex_pop = 1'b1;
      end
      op_return_load_immediate: begin
        ex_mem_use = 1'b0;
        ex_two = 1'b1;
        ex_pop = 1'b1;
        ex_acc_we = 1'b1;
        ex_acc_wd = imm;
      end
      op_table_read_current_page, op_table_read_last_page: begin
        ex_two = 1'b1;
        ex_tbl = 1'b1;
        ex_mem_we = 1'b1;
        ex_mem_wd = pm_word[7:0];
      end
      op_clr_mem: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = `BBT_RST_BYTE;
      end
      op_set_mem: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = `BBT_BYTE_ONES;
      end
      op_swap_mem: begin
        ex_mem_we = 1'b1;
        ex_mem_wd = m_swp;
      end
      op_nibble_swap_to_acc: begin
        ex_acc_we = 1'b1;
        ex_acc_wd = m_swp;
      end
      op_add_carry: begin
        ex_acc_we = 1'b1;
        ex_acc_wd = sum9[7:0];
        ex_carry_we = 1'b1;
      end
      default: ex_mem_use = 1'b0;
    endcase
  end

  // Program counter and stack; the stack wraps when overfilled
  wire pcl_wr = ex_mem_we && (m == `BBT_PCL_ADDR);
  wire [SP_W-1:0] sp_dn = sp_ff - SP_W'(1);
  wire [PC_W-1:0] pc_inc = pc_ff + PC_W'(`BBT_PC_STEP);
  wire [PC_W-1:0] pc_skp = pc_ff + PC_W'(`BBT_PC_SKIP_STEP);
  wire [PC_W-1:0] pc_pcl = {pc_ff[PC_W-1:8], ex_mem_wd};
  wire [PC_W-1:0] nxt_pc_ex = ex_pop ? stack_ff[sp_dn] :
    ex_jump ? jaddr : pcl_wr ? pc_pcl : ex_skip ? pc_skp : pc_inc;
  wire [SP_W-1:0] nxt_sp = (issue && ex_push) ? sp_ff + SP_W'(1) :
    (issue && ex_pop) ? sp_dn : sp_ff;

  // Cycle count: skip and low-byte write cost two, smart-card one more
  wire sci = ex_mem_use && (m >= SCI_BASE);
  wire [2:0] cyc_base = (ex_two || ex_skip || pcl_wr) ? `BBT_CYC_TWO : `BBT_CYC_ONE;
  wire [2:0] cyc = cyc_base + (sci ? `BBT_CYC_SCI : 3'h0);
  wire [2:0] nxt_cnt = issue ? cyc - `BBT_CYC_ONE :
    busy ? cnt_ff - `BBT_CYC_ONE : cnt_ff;
  wire done_evt = (issue && (cyc == `BBT_CYC_ONE)) || (cnt_ff == `BBT_CYC_ONE);
  wire nxt_skipped = issue ? ex_skip : skipped_ff;

  // Watchdog pre-clear pairing; any other issue breaks the pair
  wire is_w1 = op == op_watchdog_preclear_first;
  wire is_w2 = op == op_watchdog_preclear_second;
  wire pair_clr = (is_w1 && last_wdt_ff == wdt_second) ||
    (is_w2 && last_wdt_ff == wdt_first);
  wire is_halt = issue && (op == op_halt);
  wire flag_clr = issue && (pair_clr || op == op_clr_watchdog || op == op_halt);
  bbt_wdt_t nxt_last_wdt;
  assign nxt_last_wdt = !issue ? last_wdt_ff : pair_clr ? wdt_none :
    is_w1 ? wdt_first : is_w2 ? wdt_second : wdt_none;
  // Timeout pin wins over any clear in the same cycle
  wire nxt_to = to_s2_ff || (timeout_flag_ff && !flag_clr);
  wire nxt_pdf = is_halt || (powerdown_flag_ff && !flag_clr);
  // Wake by software or by a watchdog timeout
  wire wake = (wr_ctrl && hwdata[`BBT_CTRL_WAKE]) || to_s2_ff;
  wire nxt_halted = is_halt || (halted_ff && !wake);

  // Accumulator and carry: software write or executed result
  wire [7:0] nxt_accumulator = wr_acc ? hwdata[7:0] :
    (issue && ex_acc_we) ? ex_acc_wd : accumulator_ff;
  wire nxt_carry = wr_acc ? hwdata[`BBT_ACC_CARRY] :
    (issue && ex_carry_we) ? sum9[8] : carry_ff;

  // Data memory write port, shared by bus and execution
  wire mem_we = (issue && ex_mem_we) || wr_dmem;
  wire [3:0] mem_wa = issue ? m : dp_addr_ff[`BBT_F_DMEM_IDX];
  wire [7:0] mem_wd = issue ? ex_mem_wd : hwdata[7:0];

  // Interrupt status: a new event beats a write-one clear
  wire [`BBT_IRQ_W-1:0] irq_set = {overrun, is_halt, issue && ex_skip, done_evt};
  wire [`BBT_IRQ_W-1:0] irq_clr = wr_istat ? hwdata[`BBT_IRQ_W-1:0] : '0;
  wire [`BBT_IRQ_W-1:0] nxt_istat = (irq_stat_ff & ~irq_clr) | irq_set;
  wire [`BBT_IRQ_W-1:0] nxt_imask = wr_imask ? hwdata[`BBT_IRQ_W-1:0] : irq_mask_ff;

  // Read selection in the address phase
  wire [7:0] dm_rd = (ra_idx == `BBT_PCL_ADDR) ? pc_ff[7:0] : dmem_ff[ra_idx];
  wire [31:0] rd_status = {16'h0000, table_high_byte_reg_ff, 2'h0, halted_ff,
    powerdown_flag_ff, timeout_flag_ff, carry_ff, skipped_ff, busy};
  wire [31:0] rd_word = ra_dmem ? {24'h000000, dm_rd} :
    (ra == `BBT_OFF_STATUS) ? rd_status :
    (ra == `BBT_OFF_ACC) ? {23'h000000, carry_ff, accumulator_ff} :
    (ra == `BBT_OFF_PC) ? 32'(pc_ff) :
    (ra == `BBT_OFF_IRQ_STAT) ? 32'(irq_stat_ff) :
    (ra == `BBT_OFF_IRQ_MASK) ? 32'(irq_mask_ff) :
    (ra == `BBT_OFF_TPTR) ? {24'h000000, table_ptr_ff} : 32'h00000000;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= `BBT_RST_BYTE;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      dp_wr_ff <= ahb_go && hwrite;
      dp_addr_ff <= ahb_go ? ra : dp_addr_ff;
      hrdata_ff <= (ahb_go && !hwrite) ? rd_word : 32'h00000000;
    end
  end

  // Watchdog timeout pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      to_s1_ff <= 1'b0;
      to_s2_ff <= 1'b0;
    end else begin
      to_s1_ff <= wdt_timeout;
      to_s2_ff <= to_s1_ff;
    end
  end

  // Execution state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pc_ff <= '0;
      sp_ff <= '0;
      accumulator_ff <= `BBT_RST_BYTE;
      carry_ff <= 1'b0;
      cnt_ff <= 3'h0;
      skipped_ff <= 1'b0;
    end else begin
      pc_ff <= issue ? nxt_pc_ex : pc_ff;
      sp_ff <= nxt_sp;
      accumulator_ff <= nxt_accumulator;
      carry_ff <= nxt_carry;
      cnt_ff <= nxt_cnt;
      skipped_ff <= nxt_skipped;
    end
  end

  // Watchdog flags and power-down
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      last_wdt_ff <= wdt_none;
      timeout_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      last_wdt_ff <= nxt_last_wdt;
      timeout_flag_ff <= nxt_to;
      powerdown_flag_ff <= nxt_pdf;
      halted_ff <= nxt_halted;
    end
  end

  // Table pointer and high byte of table reads
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      table_ptr_ff <= `BBT_RST_BYTE;
      table_high_byte_reg_ff <= `BBT_RST_BYTE;
    end else begin
      table_ptr_ff <= wr_tptr ? hwdata[7:0] : table_ptr_ff;
      if (issue && ex_tbl) begin
        table_high_byte_reg_ff <= pm_word[15:8];
      end
    end
  end

  // Data memory; cleared at reset so skips on zero are defined
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < DM_N; i++) begin
        dmem_ff[i] <= `BBT_RST_BYTE;
      end
    end else if (mem_we) begin
      dmem_ff[mem_wa] <= mem_wd;
    end
  end

  // Program memory and stack hold data only, no reset
  always_ff @(posedge clk_sys) begin
    if (wr_pmem) begin
      pmem_ff[hwdata[`BBT_PM_ADDR_LSB +: PM_AW]] <= hwdata[`BBT_F_PM_DATA];
    end
    if (issue && ex_push) begin
      stack_ff[sp_ff] <= pc_inc;
    end
  end

  // Interrupts; level output follows the next-state values
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_istat;
      irq_mask_ff <= nxt_imask;
      irq_ff <= |(nxt_istat & nxt_imask);
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign irq = irq_ff;
  assign powered_down = halted_ff;

  // Checks on the executed behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_bit_set: assert property (issue && op == op_set_bit && m != `BBT_PCL_ADDR
    |=> dmem_ff[$past(m)][$past(bsel)] && $stable(carry_ff))
    else $error("bit set did not force one");
  a_bit_clear: assert property (issue && op == op_clr_bit && m != `BBT_PCL_ADDR
    |=> !dmem_ff[$past(m)][$past(bsel)])
    else $error("bit clear did not force zero");
  a_skip_cycles: assert property (issue && ex_skip && !sci
    |=> busy ##1 !busy)
    else $error("taken skip not two cycles");
  a_noskip_one: assert property (issue && !ex_skip && !ex_two && !pcl_wr && !sci
    |=> !busy)
    else $error("plain instruction not one cycle");
  a_pcl_two: assert property (issue && pcl_wr && !sci
    |=> busy ##1 !busy)
    else $error("low byte write not two cycles");
  a_sci_extra: assert property (issue && sci && !ex_two && !ex_skip && !pcl_wr
    |=> busy ##1 !busy)
    else $error("smart-card access lacks extra cycle");
  a_ret_imm: assert property (issue && op == op_return_load_immediate
    |=> accumulator_ff == $past(imm) && busy ##1 !busy)
    else $error("return with immediate wrong");
  a_wdt_pair: assert property (issue && is_w2 && last_wdt_ff == wdt_first && !to_s2_ff
    |=> !timeout_flag_ff && !powerdown_flag_ff)
    else $error("pre-clear pair did not clear flags");
  a_wdt_single: assert property (issue && is_w1 && last_wdt_ff != wdt_second && !to_s2_ff
    |=> $stable(timeout_flag_ff) && $stable(powerdown_flag_ff))
    else $error("lone pre-clear changed flags");
  a_halt_pd: assert property (is_halt
    |=> powered_down && powerdown_flag_ff)
    else $error("halt did not power down");
  a_skip_idle: assert property (issue && ex_skip ##1 1'b1
    |=> $stable(accumulator_ff) && $stable(pc_ff) && $stable(carry_ff))
    else $error("idle slot had side effects");
  a_add_carry: assert property (issue && op == op_add_carry
    |=> {carry_ff, accumulator_ff} ==
      9'({1'b0, $past(accumulator_ff)} + $past(m_rd) + $past(carry_ff)))
    else $error("add with carry wrong");

  c_skip: cover property (issue && ex_skip ##2 issue);
  c_pair: cover property (issue && is_w1 ##[1:8] issue && is_w2);
  c_halt: cover property (is_halt ##[1:20] !halted_ff);
  c_sci_tbl: cover property (issue && ex_tbl && sci);

endmodule : bbt_exec
`default_nettype wire

//--- hw/bbt_consts.svh
// Purpose: Constants of the branch, bit and table executor
// Assumes: 32-bit AHB-Lite data bus, one aligned word per register
// Notes: Offsets are byte addresses; ranges are field slices
`ifndef BBT_CONSTS_SVH
`define BBT_CONSTS_SVH
// Register byte offsets
`define BBT_OFF_INSTR 8'h00
`define BBT_OFF_STATUS 8'h04
`define BBT_OFF_CTRL 8'h08
`define BBT_OFF_ACC 8'h0C
`define BBT_OFF_PC 8'h10
`define BBT_OFF_IRQ_STAT 8'h14
`define BBT_OFF_IRQ_MASK 8'h18
`define BBT_OFF_PMEM 8'h1C
`define BBT_OFF_TPTR 8'h20
// Data memory window, byte index in address bits 5:2
`define BBT_F_DMEM_TAG 7:6
`define BBT_DMEM_TAG 2'h1
`define BBT_F_DMEM_IDX 5:2
`define BBT_DMEM_N 16
// Instruction word fields
`define BBT_F_OP 4:0
`define BBT_F_M 11:8
`define BBT_F_BIT 14:12
`define BBT_F_IMM 23:16
`define BBT_F_ADDR 27:16
// Program memory load word fields
`define BBT_F_PM_DATA 15:0
`define BBT_PM_ADDR_LSB 16
// Control, accumulator register fields
`define BBT_CTRL_WAKE 0
`define BBT_ACC_CARRY 8
// Interrupt bits
`define BBT_IRQ_DONE 0
`define BBT_IRQ_SKIP 1
`define BBT_IRQ_HALT 2
`define BBT_IRQ_OVR 3
`define BBT_IRQ_W 4
// Data space and values
`define BBT_PCL_ADDR 4'h0
`define BBT_BYTE_ONES 8'hFF
`define BBT_RST_BYTE 8'h00
`define BBT_PC_STEP 1
`define BBT_PC_SKIP_STEP 2
// Cycle counts
`define BBT_CYC_ONE 3'h1
`define BBT_CYC_TWO 3'h2
`define BBT_CYC_SCI 3'h1
// Bus encodings
`define BBT_HSIZE_WORD 3'h2
`endif

//--- hw/bbt_pkg.sv
// Purpose: Types of the branch, bit and table executor
// Assumes: Opcode codes are the software issue encoding
// Notes: Unlisted opcodes execute as no operation
package bbt_pkg;
  // Instruction opcodes
  typedef enum logic [4:0] {
    op_nop = 5'h00,
    op_clr_bit = 5'h01,
    op_set_bit = 5'h02,
    op_jump = 5'h03,
    op_skip_if_zero = 5'h04,
    op_skip_zero_move_acc = 5'h05,
    op_skip_bit_zero = 5'h06,
    op_skip_bit_nonzero = 5'h07,
    op_inc_skip_zero = 5'h08,
    op_dec_skip_zero = 5'h09,
    op_inc_skip_zero_to_acc = 5'h0A,
    op_dec_skip_zero_to_acc = 5'h0B,
    op_call = 5'h0C,
    op_return = 5'h0D,
    op_return_load_immediate = 5'h0E,
    op_interrupt_return = 5'h0F,
    op_table_read_current_page = 5'h10,
    op_table_read_last_page = 5'h11,
    op_clr_mem = 5'h12,
    op_set_mem = 5'h13,
    op_clr_watchdog = 5'h14,
    op_watchdog_preclear_first = 5'h15,
    op_watchdog_preclear_second = 5'h16,
    op_swap_mem = 5'h17,
    op_nibble_swap_to_acc = 5'h18,
    op_halt = 5'h19,
    op_add_carry = 5'h1A
  } bbt_op_t;
  // Last watchdog pre-clear issued
  typedef enum logic [1:0] {
    wdt_none,
    wdt_first,
    wdt_second
  } bbt_wdt_t;
endpackage : bbt_pkg

//--- sim/mcu_branch_bit_table_exec_tb.sv
// Purpose: Self-checking bench for the branch, bit and table executor
// Assumes: Zero-wait AHB-Lite slave; done interrupt marks the end of an issue
// Notes: Cycles are counted from the issue edge to the done interrupt
`timescale 1ns/1ps
`default_nettype none
`include "bbt_consts.svh"
module mcu_branch_bit_table_exec_tb;
  import bbt_pkg::*;
  typedef struct {
    bbt_op_t op;
    logic [3:0] m;
    logic [2:0] b;
    logic [7:0] imm;
    logic [7:0] mem0;
    logic [8:0] acc0;
    logic [2:0] cyc;
    logic [7:0] mem1;
    logic [8:0] acc1;
    logic sk;
  } bbt_row_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic wdt_timeout = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, powered_down;
  bbt_row_t rows[$];
  logic [7:0] rst_a [6] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h44, 8'h3C};
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [31:0] d, p;

  bbt_exec u_bbt_exec (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(`BBT_HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wdt_timeout(wdt_timeout),
    .irq(irq), .powered_down(powered_down)
  );

  // Clock at 25 MHz
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard; a full run needs well under this
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the phase until hready is sampled high at a rising edge
  task automatic phase(output logic [31:0] rd);
    logic ok;
    do begin
      @(posedge clk_sys);
      ok = hreadyout;
      rd = hrdata;
    end while (ok !== 1'b1);
  endtask : phase

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    phase(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    phase(rd);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(1'b1, a, v, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h0, v);
  endtask : rd

  // Issue after clearing status, so done alone marks the end
  task automatic issue(input bbt_op_t op, input logic [3:0] m, input logic [2:0] b,
      input logic [7:0] imm, output int cyc);
    wr(`BBT_OFF_IRQ_STAT, 32'hF);
    wr(`BBT_OFF_INSTR, {8'h00, imm, 1'b0, b, m, 3'h0, op});
    cyc = 1;
    @(negedge clk_sys);
    while (irq !== 1'b1 && cyc < 8) begin
      cyc++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask : issue

  task automatic r(input bbt_op_t op, input logic [3:0] m, input logic [2:0] b,
      input logic [7:0] imm, input logic [7:0] m0, input logic [8:0] a0, input logic [2:0] c,
      input logic [7:0] m1, input logic [8:0] a1, input logic sk);
    rows.push_back('{op, m, b, imm, m0, a0, c, m1, a1, sk});
  endtask : r

  task automatic wrap_up();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (rst_a[i]) begin
      rd(rst_a[i], d);
      chk(d, 32'h0);
    end
    chk({28'h0, hreadyout, irq, powered_down, hresp}, 32'h8);
    $display("test reset done");
    wr(`BBT_OFF_IRQ_MASK, 32'h1);
    wr(`BBT_OFF_TPTR, 32'h5);
    wr(`BBT_OFF_PMEM, 32'h0015_1234);
    wr(`BBT_OFF_PMEM, 32'h0035_BEEF);
    // Ordinary cases: op, m, bit, imm, mem in, acc in, cycles, mem out, acc out, skip
    r(op_clr_bit, 4'h1, 3'h7, 8'h00, 8'hFF, 9'h000, 3'h1, 8'h7F, 9'h000, 1'b0);
    r(op_set_bit, 4'h2, 3'h0, 8'h00, 8'h00, 9'h000, 3'h1, 8'h01, 9'h000, 1'b0);
    r(op_skip_if_zero, 4'h3, 3'h0, 8'h00, 8'h00, 9'h000, 3'h2, 8'h00, 9'h000, 1'b1);
    r(op_skip_zero_move_acc, 4'h4, 3'h0, 8'h00, 8'h00, 9'h055, 3'h2, 8'h00, 9'h000, 1'b1);
    r(op_skip_zero_move_acc, 4'h4, 3'h0, 8'h00, 8'h3C, 9'h055, 3'h1, 8'h3C, 9'h03C, 1'b0);
    r(op_skip_bit_zero, 4'h5, 3'h3, 8'h00, 8'hF7, 9'h000, 3'h2, 8'hF7, 9'h000, 1'b1);
    r(op_skip_bit_nonzero, 4'h5, 3'h3, 8'h00, 8'h08, 9'h000, 3'h2, 8'h08, 9'h000, 1'b1);
    r(op_skip_bit_nonzero, 4'h5, 3'h6, 8'h00, 8'h08, 9'h000, 3'h1, 8'h08, 9'h000, 1'b0);
    r(op_inc_skip_zero, 4'h6, 3'h0, 8'h00, 8'hFF, 9'h000, 3'h2, 8'h00, 9'h000, 1'b1);
    r(op_dec_skip_zero, 4'h7, 3'h0, 8'h00, 8'h01, 9'h000, 3'h2, 8'h00, 9'h000, 1'b1);
    r(op_dec_skip_zero, 4'h7, 3'h0, 8'h00, 8'h00, 9'h000, 3'h1, 8'hFF, 9'h000, 1'b0);
    r(op_inc_skip_zero_to_acc, 4'h8, 3'h0, 8'h00, 8'hFF, 9'h0AA, 3'h2, 8'hFF, 9'h000, 1'b1);
    r(op_dec_skip_zero_to_acc, 4'h9, 3'h0, 8'h00, 8'h05, 9'h000, 3'h1, 8'h05, 9'h004, 1'b0);
    r(op_call, 4'h1, 3'h0, 8'h20, 8'h7F, 9'h000, 3'h2, 8'h7F, 9'h000, 1'b0);
    r(op_return_load_immediate, 4'h1, 3'h0, 8'h5A, 8'h7F, 9'h100, 3'h2, 8'h7F, 9'h15A, 1'b0);
    r(op_call, 4'h1, 3'h0, 8'h30, 8'h7F, 9'h000, 3'h2, 8'h7F, 9'h000, 1'b0);
    r(op_return, 4'h1, 3'h0, 8'h00, 8'h7F, 9'h000, 3'h2, 8'h7F, 9'h000, 1'b0);
    r(op_call, 4'h1, 3'h0, 8'h30, 8'h7F, 9'h000, 3'h2, 8'h7F, 9'h000, 1'b0);
    r(op_interrupt_return, 4'h1, 3'h0, 8'h00, 8'h7F, 9'h000, 3'h2, 8'h7F, 9'h000, 1'b0);
    r(op_clr_mem, 4'h3, 3'h0, 8'h00, 8'h5A, 9'h000, 3'h1, 8'h00, 9'h000, 1'b0);
    r(op_set_mem, 4'h3, 3'h0, 8'h00, 8'h00, 9'h000, 3'h1, 8'hFF, 9'h000, 1'b0);
    r(op_swap_mem, 4'h3, 3'h0, 8'h00, 8'h3C, 9'h000, 3'h1, 8'hC3, 9'h000, 1'b0);
    r(op_nibble_swap_to_acc, 4'hA, 3'h0, 8'h00, 8'h3C, 9'h000, 3'h1, 8'h3C, 9'h0C3, 1'b0);
    r(op_add_carry, 4'hB, 3'h0, 8'h00, 8'h10, 9'h1F0, 3'h1, 8'h10, 9'h101, 1'b0);
    r(op_set_bit, 4'hE, 3'h1, 8'h00, 8'h00, 9'h000, 3'h2, 8'h02, 9'h000, 1'b0);
    r(op_skip_if_zero, 4'hF, 3'h0, 8'h00, 8'h00, 9'h000, 3'h3, 8'h00, 9'h000, 1'b1);
    r(op_jump, 4'h1, 3'h0, 8'h10, 8'h7F, 9'h000, 3'h2, 8'h7F, 9'h000, 1'b0);
    r(op_table_read_current_page, 4'hD, 3'h0, 8'h00, 8'h00, 9'h000, 3'h2, 8'h34, 9'h000, 1'b0);
    r(op_table_read_last_page, 4'hC, 3'h0, 8'h00, 8'h00, 9'h000, 3'h2, 8'hEF, 9'h000, 1'b0);
    foreach (rows[i]) begin
      wr({2'h1, rows[i].m, 2'h0}, {24'h0, rows[i].mem0});
      wr(`BBT_OFF_ACC, {23'h0, rows[i].acc0});
      issue(rows[i].op, rows[i].m, rows[i].b, rows[i].imm, n);
      chk(n, {29'h0, rows[i].cyc});
      rd({2'h1, rows[i].m, 2'h0}, d);
      chk(d, {24'h0, rows[i].mem1});
      rd(`BBT_OFF_ACC, d);
      chk(d, {23'h0, rows[i].acc1});
      rd(`BBT_OFF_STATUS, d);
      chk({31'h0, d[1]}, {31'h0, rows[i].sk});
    end
    chk({24'h0, d[15:8]}, 32'hBE);
    $display("test table done");
    // Skip advances past the discarded word
    rd(`BBT_OFF_PC, p);
    wr(8'h4C, 32'h0);
    issue(op_skip_if_zero, 4'h3, 3'h0, 8'h00, n);
    rd(`BBT_OFF_PC, d);
    chk(d, p + 32'h2);
    // Writing the low byte of the program counter
    issue(op_jump, 4'h1, 3'h0, 8'h05, n);
    issue(op_set_bit, 4'h0, 3'h7, 8'h00, n);
    chk(n, 32'h2);
    rd(`BBT_OFF_PC, d);
    chk(d, 32'h85);
    $display("test skip and pc done");
    // Halt, refused issue while halted, interrupt mask and clear
    issue(op_halt, 4'h1, 3'h0, 8'h00, n);
    chk(n, 32'h1);
    rd(`BBT_OFF_STATUS, d);
    chk({29'h0, d[5:3]}, 32'h6);
    chk({31'h0, powered_down}, 32'h1);
    wr(`BBT_OFF_INSTR, {27'h0, op_nop});
    wr(`BBT_OFF_IRQ_MASK, 32'h8);
    rd(`BBT_OFF_IRQ_STAT, d);
    chk(d & 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(`BBT_OFF_IRQ_STAT, 32'h8);
    rd(`BBT_OFF_IRQ_STAT, d);
    chk({30'h0, irq, d[3]}, 32'h0);
    wr(`BBT_OFF_CTRL, 32'h1);
    rd(`BBT_OFF_STATUS, d);
    chk({30'h0, powered_down, d[5]}, 32'h0);
    wr(`BBT_OFF_IRQ_MASK, 32'h1);
    $display("test halt done");
    // Timeout pin sets the flag; a lone pre-clear keeps both, a back to back pair or clear-watchdog clears them
    wdt_timeout <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    repeat (4) @(posedge clk_sys);
    issue(op_watchdog_preclear_first, 4'h1, 3'h0, 8'h00, n);
    issue(op_nop, 4'h1, 3'h0, 8'h00, n);
    rd(`BBT_OFF_STATUS, d);
    chk({30'h0, d[4:3]}, 32'h3);
    issue(op_watchdog_preclear_first, 4'h1, 3'h0, 8'h00, n);
    issue(op_watchdog_preclear_second, 4'h1, 3'h0, 8'h00, n);
    rd(`BBT_OFF_STATUS, d);
    chk({30'h0, d[4:3]}, 32'h0);
    wdt_timeout <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    repeat (4) @(posedge clk_sys);
    issue(op_clr_watchdog, 4'h1, 3'h0, 8'h00, n);
    rd(`BBT_OFF_STATUS, d);
    chk({31'h0, d[3]}, 32'h0);
    $display("test watchdog done");
    // Reset in mid-run clears the core state
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (rst_a[i]) begin
      rd(rst_a[i], d);
      chk(d, 32'h0);
    end
    chk({28'h0, hreadyout, irq, powered_down, hresp}, 32'h8);
    $display("test mid reset done");
    wrap_up();
  end
endmodule : mcu_branch_bit_table_exec_tb
`default_nettype wire
